// ===== include/osd_pkg.sv
package osd_pkg;
    // register offsets on the serial port
    localparam logic [7:0] REG_STATUS = 8'h03;
    localparam logic [7:0] REG_ISU    = 8'h06;
    localparam logic [7:0] REG_SRC    = 8'h08;
    // values after reset
    localparam logic [7:0] ISU_RST    = 8'h00;
    localparam logic [7:0] SRC_RST    = 8'h00;
    // interrupt_setup fields
    localparam int ISU_FB  = 0;
    localparam int ISU_PL  = 1;
    localparam int ISU_SHZ = 5;
    localparam int ISU_SHY = 6;
    localparam int ISU_SHX = 7;
    // sample_rate_config fields
    localparam int SRC_RATE_LSB = 0;
    localparam int SRC_ORIENT_DEBOUNCE_COUNT_LSB = 5;
    // orientation_status fields
    localparam int STAT_SHAKE = 7;
    localparam int STAT_ALERT = 6;
    localparam int STAT_PL    = 2;
    localparam int STAT_BF    = 0;
    // orientation codes
    localparam logic [2:0] PL_NONE  = 3'h0;
    localparam logic [2:0] PL_LEFT  = 3'h1;
    localparam logic [2:0] PL_RIGHT = 3'h2;
    localparam logic [2:0] PL_DOWN  = 3'h5;
    localparam logic [2:0] PL_UP    = 3'h6;
    localparam logic [1:0] BF_NONE  = 2'h0;
    localparam logic [1:0] BF_FRONT = 2'h1;
    localparam logic [1:0] BF_BACK  = 2'h2;
    // thresholds in milli-g
    localparam int SHAKE_MG = 1300;
    localparam int PL_Z_MG  = 800;
    localparam int BF_Z_MG  = 250;
    // sample rates per selector value, samples per second
    localparam int RATE_0 = 120;
    localparam int RATE_1 = 64;
    localparam int RATE_2 = 32;
    localparam int RATE_3 = 16;
    localparam int RATE_4 = 8;
    localparam int RATE_5 = 4;
    localparam int RATE_6 = 2;
    localparam int RATE_7 = 1;
    localparam int ACK_BIT = 8;
    // link states
    typedef enum logic [4:0] {
        LK_IDLE = 5'b00001,
        LK_ADDR = 5'b00010,
        LK_PTR  = 5'b00100,
        LK_WR   = 5'b01000,
        LK_RD   = 5'b10000
    } osd_link_t;
endpackage : osd_pkg

// ===== logic/osd_orient_shake.sv
`timescale 1ns/100ps
// Contract
// - shake when an axis sample exceeds +1.3g or falls below -1.3g.
// - only axes with their shake enable set are tested.
// - all enabled axes share one shake flag in the status.
// - shake flag clears in the ack bit of a status read.
// - decisions use the latest 6-bit sample of each axis.
// - up/down/left/right only with small Z; larger of X, Y picks pair.
// - front above +0.25g Z, back below -0.25g Z.
// - back/front changes interrupt only with bit D0 set.
// - portrait/landscape changes interrupt only with bit D1 set.
// - status holds alert bit 6, code bits 4..2, code bits 1..0.
// - reading the status drops a pending orientation interrupt.
// - sample rate comes from bits 2..0 of sample_rate_config.
// - debounce setting comes from bits 7..5 of sample_rate_config.
// - rates 1 to 120 samples per second, plus standby.
// - alert bit marks possibly invalid sample data.
// - debounce 0 updates each sample; n needs n+1 matching samples.
module osd_orient_shake
    import osd_pkg::*;
#(
    parameter int unsigned CLK_HZ    = 25_000_000,
    parameter int unsigned CNT_PER_G = 21,
    parameter logic [6:0]  DEV_ADDR  = 7'h2a // arbitrary value
) (
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       scl_clk,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       active_en,
    input  wire logic       sample_valid,
    input  wire logic       sample_alert,
    input  wire logic [5:0] x_sample,
    input  wire logic [5:0] y_sample,
    input  wire logic [5:0] z_sample,
    output logic            sample_tick,
    output logic            irq
);
    localparam logic [5:0] TH_SH = 6'(SHAKE_MG * CNT_PER_G / 1000);
    localparam logic [5:0] TH_PL = 6'(PL_Z_MG * CNT_PER_G / 1000);
    localparam logic [5:0] TH_BF = 6'(BF_Z_MG * CNT_PER_G / 1000);

    if (CNT_PER_G < 4 || CNT_PER_G > 23 || CLK_HZ < 2 * RATE_0)
    begin : g_chk
        $error("osd: CNT_PER_G or CLK_HZ out of range");
    end

    // magnitude of a two's complement sample
    function automatic logic [5:0] mag(input logic [5:0] v);
        return v[5] ? 6'(-v) : v;
    endfunction : mag

    // clock cycles between samples for a rate selector
    function automatic logic [31:0] period(input logic [2:0] s);
        case (s)
            3'h0: return 32'(CLK_HZ / RATE_0);
            3'h1: return 32'(CLK_HZ / RATE_1);
            3'h2: return 32'(CLK_HZ / RATE_2);
            3'h3: return 32'(CLK_HZ / RATE_3);
            3'h4: return 32'(CLK_HZ / RATE_4);
            3'h5: return 32'(CLK_HZ / RATE_5);
            3'h6: return 32'(CLK_HZ / RATE_6);
            default: return 32'(CLK_HZ / RATE_7);
        endcase
    endfunction : period

    // register read selection
    function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                          input logic [7:0] s,
                                          input logic [7:0] i,
                                          input logic [7:0] r);
        case (a)
            REG_STATUS: return s;
            REG_ISU:    return i;
            REG_SRC:    return r;
            default:    return 8'h00;
        endcase
    endfunction : rd_mux

    ////////////////////////////////////////////////////////////////////
    // link side, clocked by the host serial clock, except start detection clocked by the falling data line
    logic       st_tgl_q;
    logic       st_seen_q;
    osd_link_t  lk_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic       ack_q;
    logic [7:0] ptr_q;
    logic [7:0] isu_q;
    logic [7:0] src_q;
    logic       cfg_tgl_q;
    logic       rd_tgl_q;
    logic [7:0] img_q;
    logic       snap_s1_q;
    logic       snap_s2_q;
    logic       snap_seen_q;
    logic       oe_q;
    // core side signals seen by the link
    logic [7:0] snap_q;
    logic       snap_tgl_q;

    wire [7:0] byte_w  = {sh_q[6:0], sda_in};
    wire       last_w  = (bit_q == 4'(ACK_BIT));
    wire       new_st  = (st_tgl_q != st_seen_q);
    wire [7:0] ptr_nx  = ptr_q + 8'h01;
    wire [7:0] rd_now  = rd_mux(ptr_q, img_q, isu_q, src_q);
    wire [7:0] rd_next = rd_mux(ptr_nx, img_q, isu_q, src_q);

    // start condition: data falls while the serial clock is high
    always_ff @(negedge sda_in or negedge arst_n)
    begin
        if (!arst_n)
            st_tgl_q <= 1'b0;
        else if (scl_clk)
            st_tgl_q <= ~st_tgl_q;
    end

    // status image handed over from the core by toggle
    always_ff @(posedge scl_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            snap_s1_q   <= 1'b0;
            snap_s2_q   <= 1'b0;
            snap_seen_q <= 1'b0;
            img_q       <= 8'h00;
        end
        else
        begin
            snap_s1_q <= snap_tgl_q;
            snap_s2_q <= snap_s1_q;
            if (snap_s2_q != snap_seen_q)
            begin
                snap_seen_q <= snap_s2_q;
                img_q       <= snap_q;
            end
        end
    end

    // receive, address match, pointer, register writes and reads
    always_ff @(posedge scl_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_seen_q <= 1'b0;
            lk_q      <= LK_IDLE;
            bit_q     <= 4'h0;
            sh_q      <= 8'h00;
            tx_q      <= 8'h00;
            ack_q     <= 1'b0;
            ptr_q     <= 8'h00;
            isu_q     <= ISU_RST;
            src_q     <= SRC_RST;
            cfg_tgl_q <= 1'b0;
            rd_tgl_q  <= 1'b0;
        end
        else if (new_st)
        begin
            st_seen_q <= st_tgl_q;
            lk_q      <= LK_ADDR;
            bit_q     <= 4'h1;
            sh_q      <= {7'h00, sda_in};
            ack_q     <= 1'b0;
        end
        else if (!last_w)
        begin
            sh_q  <= byte_w;
            bit_q <= bit_q + 4'h1;
            if (lk_q == LK_RD)
                tx_q <= {tx_q[6:0], 1'b0};
            if (bit_q == 4'h7)
                ack_q <= (lk_q == LK_ADDR && byte_w[7:1] == DEV_ADDR)
                      || lk_q == LK_PTR || lk_q == LK_WR;
        end
        else
        begin
            bit_q <= 4'h0;
            case (lk_q)
                LK_ADDR:
                begin
                    lk_q <= !ack_q ? LK_IDLE : sh_q[0] ? LK_RD : LK_PTR;
                    tx_q <= rd_now;
                end
                LK_PTR:
                begin
                    ptr_q <= sh_q;
                    lk_q  <= LK_WR;
                end
                LK_WR:
                begin
                    if (ptr_q == REG_ISU)
                        isu_q <= sh_q;
                    if (ptr_q == REG_SRC)
                        src_q <= sh_q;
                    cfg_tgl_q <= cfg_tgl_q ^ (ptr_q == REG_ISU
                                           || ptr_q == REG_SRC);
                    ptr_q     <= ptr_nx;
                end
                LK_RD:
                begin
                    rd_tgl_q <= rd_tgl_q ^ (ptr_q == REG_STATUS);
                    ptr_q    <= ptr_nx;
                    tx_q     <= rd_next;
                    lk_q     <= sda_in ? LK_IDLE : LK_RD;
                end
                default:
                    lk_q <= LK_IDLE;
            endcase
        end
    end

    // pull the data line on the falling clock edge
    always_ff @(negedge scl_clk or negedge arst_n)
    begin
        if (!arst_n)
            oe_q <= 1'b0;
        else
            oe_q <= (last_w && ack_q)
                 || (lk_q == LK_RD && !last_w && !tx_q[7]);
    end

    assign sda_oe  = oe_q;
    assign sda_out = 1'b0; // open drain: only ever pulls low

    ////////////////////////////////////////////////////////////////////
    // core side, on the device clock
    logic [2:0]  cfg_sy_q;
    logic [2:0]  rd_sy_q;
    logic [1:0]  ack_sy_q;
    logic [7:0]  isu_c_q;
    logic [7:0]  src_c_q;
    logic [31:0] cnt_q;
    logic        tick_q;
    logic [5:0]  x_q;
    logic [5:0]  y_q;
    logic [5:0]  z_q;
    logic        eval_q;
    logic        alert_q;
    logic [4:0]  cand_q;
    logic [2:0]  match_q;
    logic [2:0]  pl_q;
    logic [1:0]  bf_q;
    logic        pend_q;
    logic        shake_q;
    logic        irq_q;

    // crossings: toggles pass two flops before use
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_sy_q <= 3'h0;
            rd_sy_q  <= 3'h0;
            ack_sy_q <= 2'h0;
        end
        else
        begin
            cfg_sy_q <= {cfg_sy_q[1:0], cfg_tgl_q};
            rd_sy_q  <= {rd_sy_q[1:0], rd_tgl_q};
            ack_sy_q <= {ack_sy_q[0], snap_seen_q};
        end
    end

    wire cfg_ev = cfg_sy_q[2] ^ cfg_sy_q[1];
    wire rd_ev  = rd_sy_q[2] ^ rd_sy_q[1];

    // configuration copies, stable while the toggle settles
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            isu_c_q <= ISU_RST;
            src_c_q <= SRC_RST;
        end
        else if (cfg_ev)
        begin
            isu_c_q <= isu_q;
            src_c_q <= src_q;
        end
    end

    wire [2:0]  rate_sel = src_c_q[SRC_RATE_LSB +: 3];
    wire [2:0]  orient_debounce_count     = src_c_q[SRC_ORIENT_DEBOUNCE_COUNT_LSB +: 3];
    wire [31:0] per_w    = period(rate_sel);
    wire        tick_d   = active_en && (cnt_q >= per_w - 32'h0000_0001);

    // sample timebase
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q  <= 32'h0000_0000;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= (tick_d || !active_en || cfg_ev) ? 32'h0000_0000
                                                       : cnt_q + 32'h1;
            tick_q <= tick_d;
        end
    end

    assign sample_tick = tick_q;

    // hold the latest 6-bit sample of each axis
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            x_q     <= 6'h00;
            y_q     <= 6'h00;
            z_q     <= 6'h00;
            alert_q <= 1'b0;
            eval_q  <= 1'b0;
        end
        else
        begin
            eval_q <= sample_valid;
            if (sample_valid)
            begin
                x_q     <= x_sample;
                y_q     <= y_sample;
                z_q     <= z_sample;
                alert_q <= sample_alert;
            end
        end
    end

    wire [5:0] ax = mag(x_q);
    wire [5:0] ay = mag(y_q);
    wire [5:0] az = mag(z_q);
    wire [2:0] sh_en = {isu_c_q[ISU_SHX], isu_c_q[ISU_SHY],
                        isu_c_q[ISU_SHZ]};
    wire [2:0] over  = {ax > TH_SH, ay > TH_SH, az > TH_SH};
    wire       hit   = eval_q && |(sh_en & over);
    wire [2:0] pl_w  = (az >= TH_PL) ? PL_NONE
                     : (ax > ay) ? (x_q[5] ? PL_UP : PL_DOWN)
                     : (y_q[5] ? PL_RIGHT : PL_LEFT);
    // back and front from Z sign and size
    wire [1:0] bf_w  = (!z_q[5] && az > TH_BF) ? BF_FRONT
                     : (z_q[5] && az > TH_BF) ? BF_BACK : BF_NONE;
    wire [4:0] cand  = {pl_w, bf_w};
    wire       same  = (cand == cand_q);
    wire [2:0] mcnt  = !same ? 3'h0
                     : (match_q == 3'h7) ? 3'h7 : match_q + 3'h1;
    wire       upd   = eval_q && (mcnt >= orient_debounce_count);
    wire       pl_ev = upd && pl_w != pl_q && isu_c_q[ISU_PL];
    wire       bf_ev = upd && bf_w != bf_q && isu_c_q[ISU_FB];
    // a new event wins over the read clear
    wire       pend_d  = pl_ev || bf_ev || (pend_q && !rd_ev);
    // clear on read, then monitoring resumes
    wire       shake_d = hit || (shake_q && !rd_ev);

    // debounce and orientation result
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cand_q  <= 5'h00;
            match_q <= 3'h0;
            pl_q    <= PL_NONE;
            bf_q    <= BF_NONE;
        end
        else if (eval_q)
        begin
            cand_q  <= cand;
            match_q <= mcnt;
            if (upd)
            begin
                pl_q <= pl_w;
                bf_q <= bf_w;
            end
        end
    end

    // flags and interrupt output
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pend_q  <= 1'b0;
            shake_q <= 1'b0;
            irq_q   <= 1'b0;
        end
        else
        begin
            pend_q  <= pend_d;
            shake_q <= shake_d;
            irq_q   <= pend_d || shake_d;
        end
    end

    assign irq = irq_q;

    wire [7:0] status = {shake_q, alert_q, 1'b0, pl_q, bf_q};

    // status image to the link, held until acknowledged
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            snap_q     <= 8'h00;
            snap_tgl_q <= 1'b0;
        end
        else if (ack_sy_q[1] == snap_tgl_q && status != snap_q)
        begin
            snap_q     <= status;
            snap_tgl_q <= ~snap_tgl_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks on the core side
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_shake_set: assert property (hit |=> shake_q && irq)
        else $error("shake not flagged");
    a_shake_mask: assert property (
        eval_q && (sh_en & over) == 3'h0 && !shake_q |=> !shake_q)
        else $error("disabled axis raised shake");
    a_shake_bit: assert property (
        eval_q && (sh_en & over) != 3'h0 |=> status[STAT_SHAKE])
        else $error("shake bit missing");
    a_read_clr: assert property (
        rd_ev && !hit |=> !shake_q)
        else $error("shake not cleared by read");
    a_pend_clr: assert property (
        rd_ev && !pl_ev && !bf_ev |=> !pend_q)
        else $error("pending not cleared by read");
    a_pl_gate: assert property (
        upd && az >= TH_PL |=> pl_q == PL_NONE)
        else $error("portrait code with large Z");
    a_bf_front: assert property (
        upd && !z_q[5] && az > TH_BF |=> bf_q == BF_FRONT)
        else $error("front not reported");
    a_irq_mask: assert property (
        !isu_c_q[ISU_FB] && !isu_c_q[ISU_PL] && !pend_q |=> !pend_q)
        else $error("orientation irq while masked");
    a_pl_irq: assert property (
        upd && isu_c_q[ISU_PL] && pl_w != pl_q |=> pend_q ##0 irq)
        else $error("portrait change without irq");
    a_orient_debounce_count_zero: assert property (
        eval_q && orient_debounce_count == 3'h0 |=> {pl_q, bf_q} == $past(cand))
        else $error("debounce 0 did not update");
    a_tick_gap: assert property (
        tick_q && per_w > 32'h1 |=> !tick_q)
        else $error("sample ticks too close");
endmodule : osd_orient_shake

// ===== verif/osd_host_model.sv
`timescale 1ns/100ps
// host side of the serial link; its clock stands high between frames
module osd_host_model
#(
    parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary value
) (
    output logic      scl_clk,
    output wire logic sda_in,
    input  wire logic sda_oe
);
    logic host_oe;
    // pulled-up data line, low while either side pulls it
    assign sda_in = ~(host_oe | sda_oe);
    initial
    begin
        scl_clk = 1'b1;
        host_oe = 1'b0;
    end
    // one bit, changed while the clock is low, sampled while high
    task automatic bit_io(input logic b, output logic r);
        host_oe = ~b;
        #16 scl_clk = 1'b1;
        #8 r = sda_in;
        #8 scl_clk = 1'b0;
    endtask : bit_io
    // start or repeated start: data falls while clock high
    task automatic go();
        host_oe = 1'b0;
        #8 scl_clk = 1'b1;
        #16 host_oe = 1'b1;
        #16 scl_clk = 1'b0;
    endtask : go
    // byte out msb first, then the device's ack
    task automatic put8(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : put8
    task automatic xfer(input logic [6:0] dev, input logic rd,
        input logic [7:0] ptr, wd, output logic [7:0] d, output logic ok);
        logic a0, a1, a2, r;
        go();
        put8({dev, 1'b0}, a0);
        put8(ptr, a1);
        if (rd)
        begin
            go();
            put8({dev, 1'b1}, a2);
            for (int i = 7; i >= 0; i--)
            begin
                bit_io(1'b1, r);
                d[i] = r;
            end
            bit_io(1'b1, r);
        end
        else
            put8(wd, a2);
        // stop: data rises while clock high
        host_oe = 1'b1;
        #16 scl_clk = 1'b1;
        #16 host_oe = 1'b0;
        #16;
        ok = a0 & a1 & a2;
    endtask : xfer
endmodule : osd_host_model

// ===== verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import osd_pkg::*;
    localparam int unsigned HZ  = 9600;
    localparam logic [6:0]  DEV = 7'h2a; // arbitrary value
    localparam logic [5:0] OX [7] = '{6'h36, 6'h0a, 6'h0a, 6'h02,
                                      6'h00, 6'h00, 6'h0a};
    localparam logic [5:0] OY [7] = '{6'h02, 6'h02, 6'h0a, 6'h36,
                                      6'h00, 6'h00, 6'h00};
    localparam logic [5:0] OZ [7] = '{6'h00, 6'h00, 6'h00, 6'h00,
                                      6'h14, 6'h2c, 6'h08};
    localparam logic [7:0] OS [7] = '{8'h18, 8'h14, 8'h04, 8'h08,
                                      8'h01, 8'h02, 8'h55};
    logic       clock, arst_n, active_en, sample_valid, sample_alert;
    logic       sda_out, sda_oe, sample_tick, irq;
    wire        scl_clk, sda_in;
    logic [5:0] x_sample, y_sample, z_sample;
    int         bad_count, n_checks, cycles;
    logic [7:0] s;

    osd_orient_shake #(
        .CLK_HZ   (HZ),
        .CNT_PER_G(21),
        .DEV_ADDR (DEV)
    ) DUT (
        .clock       (clock),
        .arst_n      (arst_n),
        .scl_clk     (scl_clk),
        .sda_in      (sda_in),
        .sda_out     (sda_out),
        .sda_oe      (sda_oe),
        .active_en   (active_en),
        .sample_valid(sample_valid),
        .sample_alert(sample_alert),
        .x_sample    (x_sample),
        .y_sample    (y_sample),
        .z_sample    (z_sample),
        .sample_tick (sample_tick),
        .irq         (irq)
    );
    osd_host_model #(.DEV_ADDR(DEV)) host (
        .scl_clk(scl_clk),
        .sda_in (sda_in),
        .sda_oe (sda_oe)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock and hang limit
    initial
        clock = 1'b0;
    always #20 clock = ~clock;
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            bad_count++;
            give_verdict();
        end
    end
    // comparisons
    task automatic chk8(input logic [7:0] g, e, input string m);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch t=%0t %s: %h not %h", $time, m, g, e);
        end
    endtask : chk8
    task automatic chk1(input logic g, e, input string m);
        chk8({7'h0, g}, {7'h0, e}, m);
    endtask : chk1
    task automatic chkn(input int g, e, input string m);
        n_checks++;
        if (g != e)
        begin
            bad_count++;
            $display("mismatch t=%0t %s: %0d not %0d", $time, m, g, e);
        end
    endtask : chkn
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    // helpers for waits, register access and samples
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] r;
        logic       k;
        host.xfer(DEV, 1'b0, a, d, r, k);
        chk1(k, 1'b1, "wr ack");
        settle(6);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic k;
        host.xfer(DEV, 1'b1, a, 8'h00, d, k);
        chk1(k, 1'b1, "rd ack");
        settle(4);
    endtask : rd
    task automatic put(input logic [5:0] x, y, z, input logic al);
        @(posedge clock);
        sample_valid <= 1'b1;
        sample_alert <= al;
        x_sample     <= x;
        y_sample     <= y;
        z_sample     <= z;
        @(posedge clock);
        sample_valid <= 1'b0;
        settle(3);
    endtask : put
    task automatic put_axis(input int a, input logic [5:0] v);
        put(a == 0 ? v : 6'h00, a == 1 ? v : 6'h00, a == 2 ? v : 6'h00, 1'b0);
    endtask : put_axis

    ////////////////////////////////////////////////////////////////////////
    // reset values, access kinds, refused frames
    task automatic t_reset();
        logic [7:0] r;
        logic       k;
        chk1(irq, 1'b0, "irq rst");
        chk1(sda_out, 1'b0, "sda level");
        rd(REG_STATUS, s);
        chk8(s, 8'h00, "stat rst");
        rd(REG_ISU, s);
        chk8(s, ISU_RST, "isu rst");
        rd(REG_SRC, s);
        chk8(s, SRC_RST, "src rst");
        host.xfer(DEV ^ 7'h01, 1'b0, REG_ISU, 8'hff, r, k);
        chk1(k, 1'b0, "foreign ack");
        wr(REG_ISU, 8'he3);
        rd(REG_ISU, s);
        chk8(s, 8'he3, "isu rw");
        wr(REG_SRC, 8'ha2);
        rd(REG_SRC, s);
        chk8(s, 8'ha2, "src rw");
        wr(REG_STATUS, 8'hff);
        rd(REG_STATUS, s);
        chk8(s, 8'h00, "stat ro");
        rd(8'h05, s);
        chk8(s, 8'h00, "unmapped");
        wr(REG_ISU, 8'h00);
        wr(REG_SRC, 8'h00);
        $display("done t_reset");
    endtask : t_reset
    // every orientation code, tie case and alert bit
    task automatic t_orient();
        wr(REG_ISU, 8'h03);
        for (int i = 0; i < 7; i++)
        begin
            put(OX[i], OY[i], OZ[i], i == 6);
            chk1(irq, 1'b1, "orient irq");
            rd(REG_STATUS, s);
            chk8(s, OS[i], "ori");
            chk1(irq, 1'b0, "irq clr");
            rd(REG_STATUS, s);
            chk8(s, OS[i], "ori again");
        end
        $display("done t_orient");
    endtask : t_orient
    // each orientation interrupt enable alone
    task automatic t_irq_en();
        wr(REG_ISU, 8'h01);
        put(6'h36, 6'h00, 6'h00, 1'b0);
        rd(REG_STATUS, s);
        put(6'h0a, 6'h00, 6'h00, 1'b0);
        chk1(irq, 1'b0, "pl masked");
        rd(REG_STATUS, s);
        chk8(s, 8'h14, "pl still");
        wr(REG_ISU, 8'h02);
        put(6'h00, 6'h36, 6'h00, 1'b0);
        chk1(irq, 1'b1, "pl irq");
        rd(REG_STATUS, s);
        put(6'h00, 6'h36, 6'h08, 1'b0);
        chk1(irq, 1'b0, "bf masked");
        wr(REG_ISU, 8'h01);
        put(6'h00, 6'h36, 6'h38, 1'b0);
        chk1(irq, 1'b1, "bf irq");
        rd(REG_STATUS, s);
        $display("done t_irq_en");
    endtask : t_irq_en
    // shake per axis: bounds, both signs, clear, disabled axis
    task automatic t_shake();
        for (int a = 0; a < 3; a++)
        begin
            wr(REG_ISU, 8'h80 >> a);
            rd(REG_STATUS, s);
            put_axis(a, 6'h1b);
            chk1(irq, 1'b0, "below 1.3g");
            put_axis(a, 6'h1c);
            chk1(irq, 1'b1, "shake pos");
            rd(REG_STATUS, s);
            chk1(s[STAT_SHAKE], 1'b1, "flag");
            chk1(irq, 1'b0, "shake clr");
            put_axis(a, 6'h24);
            chk1(irq, 1'b1, "shake neg");
            rd(REG_STATUS, s);
            rd(REG_STATUS, s);
            chk1(s[STAT_SHAKE], 1'b0, "flag clr");
            wr(REG_ISU, 8'h80 >> ((a + 1) % 3));
            put_axis(a, 6'h1f);
            chk1(irq, 1'b0, "axis off");
        end
        $display("done t_shake");
    endtask : t_shake
    // debounce of eight matching samples at 4 per second
    task automatic t_debounce();
        wr(REG_ISU, 8'h03);
        wr(REG_SRC, 8'he5);
        rd(REG_STATUS, s);
        for (int i = 0; i < 7; i++)
        begin
            put(6'h02, 6'h0a, 6'h00, 1'b0);
            chk1(irq, 1'b0, "early");
        end
        put(6'h02, 6'h0a, 6'h00, 1'b0);
        chk1(irq, 1'b1, "settled");
        rd(REG_STATUS, s);
        chk8(s, 8'h04, "deb stat");
        $display("done t_debounce");
    endtask : t_debounce
    // tick spacing for each selector, then standby
    task automatic t_rate();
        int rt [8] = '{RATE_0, RATE_1, RATE_2, RATE_3,
                       RATE_4, RATE_5, RATE_6, RATE_7};
        int n;
        for (int k = 0; k < 8; k++)
        begin
            wr(REG_SRC, k[7:0]);
            n = 0;
            while (sample_tick !== 1'b1 && n < 20000)
            begin
                settle(1);
                n++;
            end
            n = 0;
            do
            begin
                settle(1);
                n++;
            end
            while (sample_tick !== 1'b1 && n < 20000);
            chkn(n, HZ / rt[k], "tick gap");
        end
        wr(REG_SRC, 8'h00);
        @(posedge clock);
        active_en <= 1'b0;
        n = 0;
        for (int i = 0; i < 300; i++)
        begin
            settle(1);
            n += (sample_tick === 1'b1);
        end
        chkn(n, 0, "standby");
        @(posedge clock);
        active_en <= 1'b1;
        $display("done t_rate");
    endtask : t_rate

    // main sequence
    initial
    begin
        {active_en, sample_valid, sample_alert} = 3'b100;
        {x_sample, y_sample, z_sample} = 18'h0_0000;
        arst_n = 1'b0;
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        settle(2);
        t_reset();
        t_orient();
        t_irq_en();
        t_shake();
        t_debounce();
        t_rate();
        give_verdict();
    end
endmodule : tb_top
